// ---- core/dcce_defines.svh ----
/*
 Constants for the DMA CRC and checksum engine.
 Assumes one 50 MHz system clock and an AXI4-Lite register port.
*/
// What this block does
// - LFSR mode: bit order control 1 is LSB first, 0 is MSB first
// - Bits 12-8 hold polynomial length minus one; ignored in checksum mode
// - Enable bit 7 routes the selected channel through the engine
// - Write reordering on forbids unaligned transfers and setting append mode
// - Append mode absorbs data, then writes result to destination start
// - Append clear passes data through to destination, reordered if selected
// - Bit 5 selects checksum (1) or LFSR CRC (0)
// - Bits 2-0 pick which of channels 0 to 7 the engine serves
// - Writing result register seeds engine; reading returns current value
// - LFSR mode: result bits above polynomial length read zero
// - Checksum mode: only low 16 result bits used, upper read zero
// - Checksum mode: result written and read in ones complement form
// - Tap mask 1 bits enable XOR feedback at that stage
// - Checksum mode ignores the tap mask
// - Checksum mode: bit order control 1 reflects, 0 does not
// - Byte order 00 none, 01 word reverse, 10 half swap, 11 half bytes
// - Write reordering 1 reorders destination data; 0 leaves it unaltered
`ifndef DCCE_DEFINES_SVH
`define DCCE_DEFINES_SVH

`define DCCE_OFS_CONTROL 4'h0
`define DCCE_OFS_RESULT 4'h4
`define DCCE_OFS_TAPS 4'h8

`define DCCE_BIT_CH_LO 0
`define DCCE_BIT_CH_HI 2
`define DCCE_BIT_TYPE 5
`define DCCE_BIT_APPEND 6
`define DCCE_BIT_ENABLE 7
`define DCCE_BIT_POLY_LENGTH_MINUS_ONE_LO 8
`define DCCE_BIT_POLY_LENGTH_MINUS_ONE_HI 12
`define DCCE_BIT_BIT_ORDER_REFLECT 24
`define DCCE_BIT_WBO 27
`define DCCE_BIT_BYTE_ORDER_SELECT_LO 28
`define DCCE_BIT_BYTE_ORDER_SELECT_HI 29

`define DCCE_CONTROL_MASK 32'h3900_1FE7
`define DCCE_RESET_WORD 32'h0000_0000
`define DCCE_HALF_MASK 32'h0000_FFFF
`define DCCE_RESP_OKAY 2'h0
`define DCCE_RESP_SLVERR 2'h2

`define DCCE_BYTE_ORDER_SELECT_NONE 2'h0
`define DCCE_BYTE_ORDER_SELECT_WORD 2'h1
`define DCCE_BYTE_ORDER_SELECT_HALF 2'h2
`define DCCE_BYTE_ORDER_SELECT_HBYTE 2'h3

`endif

// ---- core/dcce_pkg.sv ----
/*
 Types shared by the engine files.
 Assumes the defines header is compiled alongside.
*/
package dcce_pkg;
	typedef struct packed {
		logic [31:0] data;
		logic [2:0] chan;
		logic last;
		logic append_word;
	} dcce_beat_t;

	typedef enum logic [1:0] {
		DCCE_ALGO_LFSR,
		DCCE_ALGO_IPSUM
	} dcce_algo_t;
endpackage

// ---- core/dcce_skid.sv ----
/*
 Two-entry buffer between engine and destination side.
 Assumes source and sink share clk_sys_in.
*/
`timescale 1ns/1ps
module dcce_skid
	import dcce_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input dcce_beat_t in_beat_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output dcce_beat_t out_beat_out
);
	dcce_beat_t mem_reg [DEPTH];
	logic [1:0] count_reg;
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic push;
	logic pop;

	assign in_ready_out = (count_reg != 2'(DEPTH));
	assign out_valid_out = (count_reg != 2'h0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_beat_out = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_sys_in) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_beat_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= 2'h0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + 2'(push) - 2'(pop);
		end
	end
endmodule

// ---- core/dcce_top.sv ----
/*
 DMA CRC / IP checksum engine with AXI4-Lite registers.
 Assumes the DMA offers source beats of any channel with
 valid/ready and marks the last beat of each block; the destination
 side accepts beats through a two-entry buffer.
*/
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dcce_defines.svh"
module dcce_top
	import dcce_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic src_valid_in,
	output logic src_ready_out,
	input wire logic [31:0] src_data_in,
	input wire logic [2:0] src_chan_in,
	input wire logic src_last_in,
	output logic dst_valid_out,
	input wire logic dst_ready_in,
	output logic [31:0] dst_data_out,
	output logic [2:0] dst_chan_out,
	output logic dst_last_out,
	output logic dst_append_word_out,
	output logic unaligned_allowed_out
);
	logic [31:0] control_reg;
	logic [31:0] taps_reg;
	logic [31:0] accum_reg;
	logic [31:0] accum_next;
	logic aw_held_reg;
	logic w_held_reg;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic append_pending_reg;
	logic [2:0] append_chan_reg;

	logic enable;
	logic append_mode;
	logic write_reorder_enable;
	logic bit_order_reflect;
	logic [1:0] byte_order_select;
	logic [4:0] poly_length_minus_one;
	logic [2:0] sel_ch;
	dcce_algo_t algo;
	logic chan_hit;
	logic beat_take;
	logic wr_fire;
	logic [31:0] wmask;
	logic [31:0] ctl_written;
	logic [31:0] len_mask;
	logic [31:0] result_view;
	logic [31:0] fed_data;
	logic [31:0] reordered;
	dcce_beat_t buf_in;
	dcce_beat_t buf_out;
	logic buf_in_valid;
	logic buf_in_ready;

	assign enable = control_reg[`DCCE_BIT_ENABLE];
	assign append_mode = control_reg[`DCCE_BIT_APPEND];
	assign write_reorder_enable = control_reg[`DCCE_BIT_WBO];
	assign bit_order_reflect = control_reg[`DCCE_BIT_BIT_ORDER_REFLECT];
	assign byte_order_select = control_reg[`DCCE_BIT_BYTE_ORDER_SELECT_HI:`DCCE_BIT_BYTE_ORDER_SELECT_LO];
	assign poly_length_minus_one = control_reg[`DCCE_BIT_POLY_LENGTH_MINUS_ONE_HI:`DCCE_BIT_POLY_LENGTH_MINUS_ONE_LO];
	assign sel_ch = control_reg[`DCCE_BIT_CH_HI:`DCCE_BIT_CH_LO];
	assign algo = control_reg[`DCCE_BIT_TYPE] ? DCCE_ALGO_IPSUM
		: DCCE_ALGO_LFSR;
	assign unaligned_allowed_out = !write_reorder_enable;

	// Byte order selection, shared by engine feed and destination write
	always_comb begin
		case (byte_order_select)
			`DCCE_BYTE_ORDER_SELECT_WORD: reordered = {src_data_in[7:0],
				src_data_in[15:8], src_data_in[23:16],
				src_data_in[31:24]};
			`DCCE_BYTE_ORDER_SELECT_HALF: reordered = {src_data_in[15:0],
				src_data_in[31:16]};
			`DCCE_BYTE_ORDER_SELECT_HBYTE: reordered = {src_data_in[23:16],
				src_data_in[31:24], src_data_in[7:0],
				src_data_in[15:8]};
			default: reordered = src_data_in;
		endcase
	end
	assign fed_data = reordered;

	// Only the selected channel is steered through the engine
	assign chan_hit = enable && (src_chan_in == sel_ch)
		&& (int'(sel_ch) < NUM_CH);

	// Source stalls while the append word waits for buffer room
	assign src_ready_out = buf_in_ready && !append_pending_reg;
	assign beat_take = src_valid_in && src_ready_out;

	always_comb begin
		buf_in.chan = src_chan_in;
		buf_in.last = src_last_in;
		buf_in.append_word = 1'b0;
		buf_in.data = (chan_hit && write_reorder_enable) ? reordered
			: src_data_in;
		buf_in_valid = src_valid_in && !append_pending_reg
			&& !(chan_hit && append_mode);
		if (append_pending_reg) begin
			buf_in.chan = append_chan_reg;
			buf_in.last = 1'b1;
			buf_in.append_word = 1'b1;
			buf_in.data = result_view;
			buf_in_valid = 1'b1;
		end
	end

	// Absorbed beats still need buffer ready so ordering is kept simple
	dcce_skid #(
		.DEPTH(2)
	) u_skid (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(buf_in_valid),
		.in_ready_out(buf_in_ready),
		.in_beat_in(buf_in),
		.out_valid_out(dst_valid_out),
		.out_ready_in(dst_ready_in),
		.out_beat_out(buf_out)
	);
	assign dst_data_out = buf_out.data;
	assign dst_chan_out = buf_out.chan;
	assign dst_last_out = buf_out.last;
	assign dst_append_word_out = buf_out.append_word;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			append_pending_reg <= 1'b0;
			append_chan_reg <= 3'h0;
		end else if (append_pending_reg) begin
			if (buf_in_ready)
				append_pending_reg <= 1'b0;
		end else if (beat_take && chan_hit && append_mode
			&& src_last_in) begin
			append_pending_reg <= 1'b1;
			append_chan_reg <= src_chan_in;
		end
	end

	// One 32-bit step of the engine per beat
	function automatic logic [31:0] engine_step(
		input logic [31:0] acc,
		input logic [31:0] din,
		input dcce_algo_t a,
		input logic refl,
		input logic [4:0] pl,
		input logic [31:0] taps
	);
		logic [31:0] s;
		logic [16:0] sum;
		logic fb;
		logic dbit;
		logic [31:0] d;
		s = acc;
		sum = 17'h0_0000;
		fb = 1'b0;
		dbit = 1'b0;
		d = din;
		if (a == DCCE_ALGO_IPSUM) begin
			// Reflection swaps bit order within each half-word
			if (refl) begin
				for (int j = 0; j < 16; j++) begin
					d[j] = din[15 - j];
					d[16 + j] = din[31 - j];
				end
			end
			sum = {1'b0, acc[15:0]} + {1'b0, d[15:0]};
			sum = {1'b0, sum[15:0]} + {16'h0000, sum[16]};
			sum = {1'b0, sum[15:0]} + {1'b0, d[31:16]};
			sum = {1'b0, sum[15:0]} + {16'h0000, sum[16]};
			s = {16'h0000, sum[15:0]};
		end else begin
			for (int i = 0; i < 32; i++) begin
				dbit = refl ? din[i] : din[31 - i];
				fb = s[pl] ^ dbit;
				s = {s[30:0], 1'b0};
				s = s ^ (taps & {32{fb}});
			end
		end
		return s;
	endfunction

	// Internal sum is the raw ones complement accumulation
	assign len_mask = 32'hFFFF_FFFF >> (5'd31 - poly_length_minus_one);
	always_comb begin
		if (algo == DCCE_ALGO_IPSUM)
			result_view = ~accum_reg & `DCCE_HALF_MASK;
		else
			result_view = accum_reg & len_mask;
	end

	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	always_comb begin
		accum_next = accum_reg;
		if (wr_fire && awaddr_reg == `DCCE_OFS_RESULT) begin
			accum_next = (result_view & ~wmask) | (wdata_reg & wmask);
			if (algo == DCCE_ALGO_IPSUM)
				accum_next = ~accum_next & `DCCE_HALF_MASK;
		end else if (beat_take && chan_hit) begin
			accum_next = engine_step(accum_reg, fed_data, algo, bit_order_reflect,
				poly_length_minus_one, taps_reg);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			accum_reg <= `DCCE_RESET_WORD;
		else
			accum_reg <= accum_next;
	end

	// Append bit is dropped whenever write reordering ends up set
	always_comb begin
		ctl_written = ((control_reg & ~wmask) | (wdata_reg & wmask))
			& `DCCE_CONTROL_MASK;
		if (ctl_written[`DCCE_BIT_WBO])
			ctl_written[`DCCE_BIT_APPEND] = 1'b0;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			control_reg <= `DCCE_RESET_WORD;
		else if (wr_fire && awaddr_reg == `DCCE_OFS_CONTROL)
			control_reg <= ctl_written;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in)
			taps_reg <= `DCCE_RESET_WORD;
		else if (wr_fire && awaddr_reg == `DCCE_OFS_TAPS)
			taps_reg <= (taps_reg & ~wmask) | (wdata_reg & wmask);
	end

	// Write channels: address and data caught independently
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= `DCCE_RESET_WORD;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DCCE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == `DCCE_OFS_CONTROL
					|| awaddr_reg == `DCCE_OFS_RESULT
					|| awaddr_reg == `DCCE_OFS_TAPS)
					? `DCCE_RESP_OKAY : `DCCE_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one cycle from address to data
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `DCCE_RESET_WORD;
			s_axi_rresp <= `DCCE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `DCCE_RESP_OKAY;
			case (s_axi_araddr)
				`DCCE_OFS_CONTROL: s_axi_rdata <= control_reg;
				`DCCE_OFS_RESULT: s_axi_rdata <= result_view;
				`DCCE_OFS_TAPS: s_axi_rdata <= taps_reg;
				default: begin
					s_axi_rdata <= `DCCE_RESET_WORD;
					s_axi_rresp <= `DCCE_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- sim/dcce_top_assertions.sv ----
/*
 Port checks for dcce_top.
 Assumes it is bound onto each dcce_top instance.
*/
`timescale 1ns/1ps
`include "dcce_defines.svh"
module dcce_top_checker #(
	parameter int NUM_CH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dst_valid_out,
	input wire logic dst_ready_in,
	input wire logic [31:0] dst_data_out,
	input wire logic dst_last_out,
	input wire logic dst_append_word_out,
	input wire logic unaligned_allowed_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	logic whs;
	assign whs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read not answered");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_write_answer: assert property (whs |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_slverr_map: assert property (whs && s_axi_awaddr == 4'hC
		|-> ##[1:2] s_axi_bvalid && s_axi_bresp == `DCCE_RESP_SLVERR)
		else $error("unmapped write not refused");
	chk_dst_hold: assert property (dst_valid_out && !dst_ready_in
		|=> dst_valid_out && $stable(dst_data_out) && $stable(dst_last_out))
		else $error("destination beat moved");
	chk_append_last: assert property (dst_valid_out &&
		dst_append_word_out |-> dst_last_out) else $error("append not last");
	chk_wbo_lock: assert property (whs && s_axi_awaddr == 4'h0 &&
		s_axi_wstrb[3] && s_axi_wdata[27] |-> ##[1:2] !unaligned_allowed_out)
		else $error("unaligned still allowed");
endmodule
bind dcce_top dcce_top_checker #(.NUM_CH(NUM_CH)) chk_i (.*);

// ---- sim/dcce_dma_model.sv ----
/*
 DMA channel stand-in: offers source beats, sinks destination beats.
 Assumes the bench fills tx_q and reads rx_q by hierarchy.
*/
`timescale 1ns/1ps
module dcce_dma_model (
	input wire logic clk_in,
	input wire logic stall_in,
	output logic sv_out,
	input wire logic sr_in,
	output logic [31:0] sd_out,
	output logic [2:0] sc_out,
	output logic sl_out,
	input wire logic dv_in,
	output logic dr_out,
	input wire logic [31:0] dd_in,
	input wire logic [2:0] dc_in,
	input wire logic dl_in,
	input wire logic da_in
);
	logic [35:0] tx_q[$];
	logic [33:0] rx_q[$];
	logic [2:0] rc_q[$];
	initial begin
		sv_out = 1'b0;
		sd_out = 32'h0000_0000;
		sc_out = 3'h0;
		sl_out = 1'b0;
		dr_out = 1'b0;
	end
	always @(posedge clk_in) begin
		if (dv_in && dr_out) begin
			rx_q.push_back({da_in, dl_in, dd_in});
			rc_q.push_back(dc_in);
		end
		dr_out <= !stall_in;
		if (!sv_out || sr_in) begin
			sv_out <= tx_q.size() > 0;
			// Idle bus inverts the data word each cycle instead of holding it
			if (tx_q.size() > 0)
				{sc_out, sl_out, sd_out} <= tx_q.pop_front();
			else
				sd_out <= ~sd_out;
		end
	end
endmodule

// ---- sim/dcce_top_tb_top.sv ----
/*
 Self-checking bench for dcce_top.
 Assumes the DMA model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "dcce_defines.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module dcce_top_tb_top;
	logic clk_sys_in, rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, src_valid_in;
	logic src_ready_out, src_last_in, dst_valid_out, dst_ready_in;
	logic dst_last_out, dst_append_word_out, unaligned_allowed_out, stall;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, src_data_in, dst_data_out;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] src_chan_in, dst_chan_out;
	logic [31:0] d;
	int n_fail, tests_run;
	dcce_top DUT (.*);
	dcce_dma_model pdm (.clk_in(clk_sys_in), .stall_in(stall),
		.sv_out(src_valid_in), .sr_in(src_ready_out), .sd_out(src_data_in),
		.sc_out(src_chan_in), .sl_out(src_last_in), .dv_in(dst_valid_out),
		.dr_out(dst_ready_in), .dd_in(dst_data_out),
		.dc_in(dst_chan_out), .dl_in(dst_last_out),
		.da_in(dst_append_word_out));
	always #10 clk_sys_in = ~clk_sys_in;
	function automatic logic [31:0] swp(logic [31:0] x, logic [1:0] m);
		case (m)
			2'h1: return {x[7:0], x[15:8], x[23:16], x[31:24]};
			2'h2: return {x[15:0], x[31:16]};
			2'h3: return {x[23:16], x[31:24], x[7:0], x[15:8]};
			default: return x;
		endcase
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		bit ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk_sys_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			ta |= s_axi_awready;
			tw |= s_axi_wready;
			s_axi_awvalid <= !ta;
			s_axi_wvalid <= !tw;
		end while (!(ta && tw));
		while (!s_axi_bvalid) @(posedge clk_sys_in);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys_in); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys_in); while (!s_axi_rvalid);
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		`CHK("rdata", e, s_axi_rdata)
	endtask
	task automatic put(input logic [31:0] v, input logic [2:0] c, input logic l);
		pdm.tx_q.push_back({c, l, v});
	endtask
	task automatic get(input int n);
		for (int k = 0; k < 200 && pdm.rx_q.size() < n; k++)
			@(posedge clk_sys_in);
	endtask
	task automatic t_regs;
		rd(4'h0, 32'h0000_0000);
		rd(4'h4, 32'h0000_0000);
		rd(4'h8, 32'h0000_0000);
		rd(4'hC, 32'h0000_0000);
		`CHK("rresp", `DCCE_RESP_SLVERR, r)
		wr(4'h8, 32'hA5A5_0F0F);
		rd(4'h8, 32'hA5A5_0F0F);
		wr(4'hC, 32'hFFFF_FFFF);
		`CHK("bresp", `DCCE_RESP_SLVERR, r)
	endtask
	task automatic t_lock;
		wr(4'h0, 32'h0800_00C0);
		rd(4'h0, 32'h0800_0080);
		`CHK("unaligned", 1'b0, unaligned_allowed_out)
		wr(4'h0, 32'h0000_0000);
		`CHK("unaligned", 1'b1, unaligned_allowed_out)
	endtask
	task automatic t_poly_length_minus_one;
		wr(4'h0, 32'h0000_0700);
		wr(4'h4, 32'hFFFF_FFFF);
		rd(4'h4, 32'h0000_00FF);
		wr(4'h0, 32'h0000_1F00);
		rd(4'h4, 32'hFFFF_FFFF);
	endtask
	task automatic t_pass;
		for (int m = 0; m < 4; m++) begin
			wr(4'h0, {2'h0, 2'(m), 28'h800_0082});
			put(32'h1122_3344, 3'h2, 1'b1);
			get(1);
			`CHK("reorder", {2'h1, swp(32'h1122_3344, 2'(m))}, pdm.rx_q[0])
			pdm.rx_q.delete();
		end
		wr(4'h0, 32'h1000_0082);
		put(32'h1122_3344, 3'h2, 1'b1);
		get(1);
		`CHK("plain", {2'h1, 32'h1122_3344}, pdm.rx_q[0])
		// Engine off: append bit must not swallow the beat
		wr(4'h0, 32'h0000_0042);
		put(32'h0BAD_F00D, 3'h2, 1'b1);
		get(2);
		`CHK("bypass", {2'h1, 32'h0BAD_F00D}, pdm.rx_q[1])
		pdm.rx_q.delete();
	endtask
	task automatic t_stall;
		stall <= 1'b1;
		for (int i = 1; i < 4; i++)
			put(32'(i), 3'h5, 1'b1);
		repeat (10) @(posedge clk_sys_in);
		`CHK("src_ready", 1'b0, src_ready_out)
		`CHK("held", 0, pdm.rx_q.size())
		stall <= 1'b0;
		get(3);
		for (int i = 1; i < 4; i++)
			`CHK("order", {2'h1, 32'(i)}, pdm.rx_q[i - 1])
		pdm.rx_q.delete();
	endtask
	task automatic t_sum;
		wr(4'h0, 32'h0000_0020);
		wr(4'h4, 32'hABCD_FFFF);
		rd(4'h4, 32'h0000_FFFF);
		wr(4'h0, 32'h0000_00E2);
		pdm.rc_q.delete();
		put(32'h5555_AAAA, 3'h3, 1'b1);
		put(32'h0001_0002, 3'h2, 1'b0);
		put(32'h0003_0004, 3'h2, 1'b1);
		get(2);
		repeat (8) @(posedge clk_sys_in);
		`CHK("count", 2, pdm.rx_q.size())
		`CHK("other_ch", {2'h1, 32'h5555_AAAA}, pdm.rx_q[0])
		`CHK("append", {2'h3, 32'h0000_FFF5}, pdm.rx_q[1])
		`CHK("other_chan", 3'h3, pdm.rc_q[0])
		`CHK("append_chan", 3'h2, pdm.rc_q[1])
		rd(4'h4, 32'h0000_FFF5);
	endtask
	// CRC-8 style taps: a single 1 bit fed last leaves exactly the taps
	task automatic t_lfsr;
		pdm.rx_q.delete();
		wr(4'h8, 32'h0000_0007);
		wr(4'h0, 32'h0000_0782);
		wr(4'h4, 32'h0000_0000);
		put(32'h0000_0001, 3'h2, 1'b1);
		get(1);
		rd(4'h4, 32'h0000_0007);
		wr(4'h0, 32'h0100_0782);
		wr(4'h4, 32'h0000_0000);
		put(32'h8000_0000, 3'h2, 1'b1);
		get(2);
		rd(4'h4, 32'h0000_0007);
		wr(4'h0, 32'h0100_00A2);
		wr(4'h4, 32'h0000_FFFF);
		put(32'h0001_0002, 3'h2, 1'b1);
		get(3);
		rd(4'h4, 32'h0000_3FFF);
		pdm.rx_q.delete();
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		end_sim();
	end
	initial begin
		{clk_sys_in, rst_n_in, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, stall} = 4'h0;
		{s_axi_awaddr, s_axi_araddr} = 8'h00;
		s_axi_wstrb = 4'hF;
		s_axi_wdata = 32'h0000_0000;
		repeat (4) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_lock();
		t_poly_length_minus_one();
		t_pass();
		t_stall();
		t_sum();
		t_lfsr();
		end_sim();
	end
endmodule
